// File: rtl/tic_pkg.sv
// Shared constants and types for the timer input capture unit
package tic_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] TIMER1_CAPTURE_EDGE_CONTROL_IDX = 8'h6A;
    localparam logic [7:0] TIMER1_CAPTURE_A_LOW_IDX = 8'h6B;
    localparam logic [7:0] TIMER1_CAPTURE_A_HIGH_IDX = 8'h6C;
    localparam logic [7:0] TIMER1_CAPTURE_B_LOW_IDX = 8'h6D;
    localparam logic [7:0] TIMER1_CAPTURE_B_HIGH_IDX = 8'h6E;
    localparam logic [7:0] TIMER3_CAPTURE_EDGE_CONTROL_IDX = 8'h7B;
    localparam logic [7:0] TIMER3_CAPTURE_A_LOW_IDX = 8'h7C;
    localparam logic [7:0] TIMER3_CAPTURE_A_HIGH_IDX = 8'h7D;
    localparam logic [7:0] TIMER3_CAPTURE_B_LOW_IDX = 8'h7E;
    localparam logic [7:0] TIMER3_CAPTURE_B_HIGH_IDX = 8'h7F;

    // Offsets of each register from its timer's control register
    localparam int TIC_OFS_CTL = 0;
    localparam int TIC_OFS_A_LOW = 1;
    localparam int TIC_OFS_A_HIGH = 2;
    localparam int TIC_OFS_B_LOW = 3;
    localparam int TIC_OFS_B_HIGH = 4;
    localparam int TIC_REGS_PER_TIMER = 5;

    localparam int TIC_TIMERS = 2;
    localparam int TIC_PINS = 4;
    localparam int TIC_CNT_W = 16;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int TIC_SEL_W = 2;
    localparam int TIC_SEL_A_LSB = 0;
    localparam int TIC_SEL_B_LSB = 2;
    localparam int TIC_SEL_FALL_BIT = 0;
    localparam int TIC_SEL_RISE_BIT = 1;
    localparam logic [1:0] TIC_EDGE_OFF = 2'h0;
    localparam logic [1:0] TIC_EDGE_FALL = 2'h1;
    localparam logic [1:0] TIC_EDGE_RISE = 2'h2;
    localparam logic [1:0] TIC_EDGE_BOTH = 2'h3;

    localparam logic [7:0] TIC_CTL_RESET = 8'h00;
    localparam logic [15:0] TIC_CAP_RESET = 16'h0000;
    localparam logic [31:0] TIC_RDATA_RESET = 32'h0000_0000;

    // ****************************************************************
    // Whole state of the unit
    // ****************************************************************
    typedef struct packed {
        logic [TIC_PINS-1:0] sync1;
        logic [TIC_PINS-1:0] sync2;
        logic [TIC_PINS-1:0] prev;
        logic [TIC_TIMERS-1:0][7:0] ctl;
        logic [TIC_PINS-1:0][TIC_CNT_W-1:0] cap;
        logic [31:0] rdata;
        logic err;
    } tic_state_t;

endpackage

// File: rtl/tic_capture.sv
// Input capture unit for timers 1 and 3 with an APB register slave
`timescale 1ns/1ps
`default_nettype none

module tic_capture #(
    parameter int ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] timer1_count,
    input wire logic [15:0] timer3_count,
    input wire logic capture_pin_0,
    input wire logic capture_pin_1,
    input wire logic capture_pin_2,
    input wire logic capture_pin_3
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam logic [1:0][7:0] BASE_IDX = {tic_pkg::TIMER3_CAPTURE_EDGE_CONTROL_IDX,
                                            tic_pkg::TIMER1_CAPTURE_EDGE_CONTROL_IDX};

    tic_pkg::tic_state_t state_reg;
    tic_pkg::tic_state_t state_next;
    logic [tic_pkg::TIC_PINS-1:0] pins;
    logic [1:0] sel_v;
    logic rise_v;
    logic fall_v;
    logic [7:0] byte_v;
    logic setup_phase;
    logic write_access;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a == ADDR_W'({idx, 2'h0});
    endfunction

    // Pin 0/1 feed timer 1 inputs A/B, pins 2/3 feed timer 3 inputs A/B
    assign pins = {capture_pin_3, capture_pin_2, capture_pin_1, capture_pin_0};
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite;

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && state_reg.err;
    assign prdata = state_reg.rdata;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;
        sel_v = tic_pkg::TIC_EDGE_OFF;
        rise_v = 1'b0;
        fall_v = 1'b0;
        byte_v = 8'h00;

        // Two-stage synchronizer, then one more stage for edge compare
        state_next.sync1 = pins;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;

        for (int i = 0; i < tic_pkg::TIC_PINS; i++)
        begin
            // Even pins are input A (bits 1:0), odd pins input B (bits 3:2)
            sel_v = state_reg.ctl[i / 2][(i % 2) * tic_pkg::TIC_SEL_W +: tic_pkg::TIC_SEL_W];
            rise_v = state_reg.sync2[i] && !state_reg.prev[i];
            fall_v = !state_reg.sync2[i] && state_reg.prev[i];
            if ((rise_v && sel_v[tic_pkg::TIC_SEL_RISE_BIT]) ||
                (fall_v && sel_v[tic_pkg::TIC_SEL_FALL_BIT]))
            begin
                state_next.cap[i] = (i < 2) ? timer1_count : timer3_count;
            end
        end

        // Read data and error are prepared in the setup cycle so prdata is a flop
        if (setup_phase)
        begin
            state_next.err = 1'b1;
            state_next.rdata = tic_pkg::TIC_RDATA_RESET;
            for (int t = 0; t < tic_pkg::TIC_TIMERS; t++)
            begin
                for (int o = 0; o < tic_pkg::TIC_REGS_PER_TIMER; o++)
                begin
                    if (addr_hit(paddr, 8'(BASE_IDX[t] + 8'(o))))
                    begin
                        case (o)
                            tic_pkg::TIC_OFS_CTL: byte_v = state_reg.ctl[t];
                            tic_pkg::TIC_OFS_A_LOW: byte_v = state_reg.cap[2 * t][7:0];
                            tic_pkg::TIC_OFS_A_HIGH: byte_v = state_reg.cap[2 * t][15:8];
                            tic_pkg::TIC_OFS_B_LOW: byte_v = state_reg.cap[2 * t + 1][7:0];
                            tic_pkg::TIC_OFS_B_HIGH: byte_v = state_reg.cap[2 * t + 1][15:8];
                            default: byte_v = 8'h00;
                        endcase
                        state_next.err = 1'b0;
                        if (!pwrite)
                        begin
                            state_next.rdata = {24'h000000, byte_v};
                        end
                    end
                end
            end
        end

        // Only the control registers take writes; capture values ignore them
        if (write_access)
        begin
            for (int t = 0; t < tic_pkg::TIC_TIMERS; t++)
            begin
                if (addr_hit(paddr, BASE_IDX[t]))
                begin
                    // Upper bits are stored as written; software keeps them zero
                    state_next.ctl[t] = pwdata[7:0];
                end
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg.sync1 <= '0;
            state_reg.sync2 <= '0;
            state_reg.prev <= '0;
            state_reg.ctl <= {tic_pkg::TIC_CTL_RESET, tic_pkg::TIC_CTL_RESET};
            state_reg.cap <= {tic_pkg::TIC_PINS{tic_pkg::TIC_CAP_RESET}};
            state_reg.rdata <= tic_pkg::TIC_RDATA_RESET;
            state_reg.err <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    t1a_rise_cap_a: assert property (
        state_reg.ctl[0][1:0] == tic_pkg::TIC_EDGE_RISE && state_reg.sync2[0] && !state_reg.prev[0]
        |=> state_reg.cap[0] == $past(timer1_count))
        else $error("timer1 input A missed a rising edge capture");

    t1a_fall_cap_a: assert property (
        state_reg.ctl[0][1:0] == tic_pkg::TIC_EDGE_FALL && !state_reg.sync2[0] && state_reg.prev[0]
        |=> state_reg.cap[0] == $past(timer1_count))
        else $error("timer1 input A missed a falling edge capture");

    t1a_both_cap_a: assert property (
        state_reg.ctl[0][1:0] == tic_pkg::TIC_EDGE_BOTH && state_reg.sync2[0] != state_reg.prev[0]
        |=> state_reg.cap[0] == $past(timer1_count))
        else $error("timer1 input A missed an edge in both-edge mode");

    t1a_fall_skip_a: assert property (
        state_reg.ctl[0][1:0] == tic_pkg::TIC_EDGE_RISE && !state_reg.sync2[0] && state_reg.prev[0]
        |=> $stable(state_reg.cap[0]))
        else $error("timer1 input A captured a falling edge in rising mode");

    t1b_rise_cap_a: assert property (
        state_reg.ctl[0][3:2] == tic_pkg::TIC_EDGE_RISE && state_reg.sync2[1] && !state_reg.prev[1]
        |=> state_reg.cap[1] == $past(timer1_count))
        else $error("timer1 input B missed a rising edge capture");

    t1b_fall_cap_a: assert property (
        state_reg.ctl[0][3:2] == tic_pkg::TIC_EDGE_FALL && !state_reg.sync2[1] && state_reg.prev[1]
        |=> state_reg.cap[1] == $past(timer1_count))
        else $error("timer1 input B missed a falling edge capture");

    t1b_both_cap_a: assert property (
        state_reg.ctl[0][3:2] == tic_pkg::TIC_EDGE_BOTH && state_reg.sync2[1] != state_reg.prev[1]
        |=> state_reg.cap[1] == $past(timer1_count))
        else $error("timer1 input B missed an edge in both-edge mode");

    t3a_rise_cap_a: assert property (
        state_reg.ctl[1][1:0] == tic_pkg::TIC_EDGE_RISE && state_reg.sync2[2] && !state_reg.prev[2]
        |=> state_reg.cap[2] == $past(timer3_count))
        else $error("timer3 input A missed a rising edge capture");

    t3a_fall_cap_a: assert property (
        state_reg.ctl[1][1:0] == tic_pkg::TIC_EDGE_FALL && !state_reg.sync2[2] && state_reg.prev[2]
        |=> state_reg.cap[2] == $past(timer3_count))
        else $error("timer3 input A missed a falling edge capture");

    t3b_fall_cap_a: assert property (
        state_reg.ctl[1][3:2] == tic_pkg::TIC_EDGE_FALL && !state_reg.sync2[3] && state_reg.prev[3]
        |=> state_reg.cap[3] == $past(timer3_count))
        else $error("timer3 input B missed a falling edge capture");

    t3b_rise_cap_a: assert property (
        state_reg.ctl[1][3:2] == tic_pkg::TIC_EDGE_RISE && state_reg.sync2[3] && !state_reg.prev[3]
        |=> state_reg.cap[3] == $past(timer3_count))
        else $error("timer3 input B missed a rising edge capture");

    t3b_both_cap_a: assert property (
        state_reg.ctl[1][3:2] == tic_pkg::TIC_EDGE_BOTH && state_reg.sync2[3] != state_reg.prev[3]
        |=> state_reg.cap[3] == $past(timer3_count))
        else $error("timer3 input B missed an edge in both-edge mode");

    t3b_rise_skip_a: assert property (
        state_reg.ctl[1][3:2] == tic_pkg::TIC_EDGE_FALL && state_reg.sync2[3] && !state_reg.prev[3]
        |=> $stable(state_reg.cap[3]))
        else $error("timer3 input B captured a rising edge in falling mode");

    t1b_rise_skip_a: assert property (
        state_reg.ctl[0][3:2] == tic_pkg::TIC_EDGE_FALL && state_reg.sync2[1] && !state_reg.prev[1]
        |=> $stable(state_reg.cap[1]))
        else $error("timer1 input B captured a rising edge in falling mode");

    t3a_both_cap_a: assert property (
        state_reg.ctl[1][1:0] == tic_pkg::TIC_EDGE_BOTH && state_reg.sync2[2] != state_reg.prev[2]
        |=> state_reg.cap[2] == $past(timer3_count))
        else $error("timer3 input A missed an edge in both-edge mode");

    disabled_hold_a: assert property (
        state_reg.ctl[0][1:0] == tic_pkg::TIC_EDGE_OFF |=> $stable(state_reg.cap[0]))
        else $error("timer1 input A changed while capture disabled");

    t1b_off_hold_a: assert property (
        state_reg.ctl[0][3:2] == tic_pkg::TIC_EDGE_OFF |=> $stable(state_reg.cap[1]))
        else $error("timer1 input B changed while capture disabled");

    t3a_off_hold_a: assert property (
        state_reg.ctl[1][1:0] == tic_pkg::TIC_EDGE_OFF |=> $stable(state_reg.cap[2]))
        else $error("timer3 input A changed while capture disabled");

    t3b_off_hold_a: assert property (
        state_reg.ctl[1][3:2] == tic_pkg::TIC_EDGE_OFF |=> $stable(state_reg.cap[3]))
        else $error("timer3 input B changed while capture disabled");

    no_edge_hold_a: assert property (
        state_reg.sync2 == state_reg.prev |=> $stable(state_reg.cap))
        else $error("capture value changed without an input edge");

    pin_sync_a: assert property (
        $rose(capture_pin_1) ##1 capture_pin_1 |=> state_reg.sync2[1] && !state_reg.prev[1])
        else $error("pin 1 edge not seen two cycles after it arrived");

    ctl_write_a: assert property (
        write_access && paddr == ADDR_W'({tic_pkg::TIMER3_CAPTURE_EDGE_CONTROL_IDX, 2'h0})
        |=> state_reg.ctl[1] == $past(pwdata[7:0]))
        else $error("timer3 control write not stored");

    t1_ctl_write_a: assert property (
        write_access && paddr == ADDR_W'({tic_pkg::TIMER1_CAPTURE_EDGE_CONTROL_IDX, 2'h0})
        |=> state_reg.ctl[0] == $past(pwdata[7:0]))
        else $error("timer1 control write not stored");

    ctl_hold_a: assert property (
        !write_access |=> $stable(state_reg.ctl))
        else $error("control register changed without a write");

    ctl_read_a: assert property (
        setup_phase && !pwrite
        && paddr == ADDR_W'({tic_pkg::TIMER1_CAPTURE_EDGE_CONTROL_IDX, 2'h0})
        ##1 psel && penable |-> prdata == {24'h000000, $past(state_reg.ctl[0])})
        else $error("timer1 control read returned wrong data");

    a_low_read_a: assert property (
        setup_phase && !pwrite && paddr == ADDR_W'({tic_pkg::TIMER1_CAPTURE_A_LOW_IDX, 2'h0})
        |=> prdata == {24'h000000, $past(state_reg.cap[0][7:0])} && !pslverr)
        else $error("timer1 input A low byte read wrong");

    a_high_read_a: assert property (
        setup_phase && !pwrite && paddr == ADDR_W'({tic_pkg::TIMER3_CAPTURE_A_HIGH_IDX, 2'h0})
        |=> prdata == {24'h000000, $past(state_reg.cap[2][15:8])})
        else $error("timer3 input A high byte read wrong");

    b_low_read_a: assert property (
        setup_phase && !pwrite && paddr == ADDR_W'({tic_pkg::TIMER1_CAPTURE_B_LOW_IDX, 2'h0})
        |=> prdata == {24'h000000, $past(state_reg.cap[1][7:0])})
        else $error("timer1 input B low byte read wrong");

    b_high_read_a: assert property (
        setup_phase && !pwrite && paddr == ADDR_W'({tic_pkg::TIMER3_CAPTURE_B_HIGH_IDX, 2'h0})
        |=> prdata == {24'h000000, $past(state_reg.cap[3][15:8])})
        else $error("timer3 input B high byte read wrong");

    cap_ro_a: assert property (
        write_access && paddr == ADDR_W'({tic_pkg::TIMER1_CAPTURE_A_HIGH_IDX, 2'h0})
        && !(state_reg.sync2[0] ^ state_reg.prev[0])
        |=> $stable(state_reg.cap[0]))
        else $error("write changed a read-only capture value");

    t3b_ro_write_a: assert property (
        write_access && paddr == ADDR_W'({tic_pkg::TIMER3_CAPTURE_B_LOW_IDX, 2'h0})
        && !(state_reg.sync2[3] ^ state_reg.prev[3])
        |=> $stable(state_reg.cap[3]))
        else $error("write changed timer3 input B capture value");

endmodule

`default_nettype wire

// File: bench/tic_pin_src.sv
// Model of the external signal sources on the four capture pins
`timescale 1ns/1ps
`default_nettype none

module tic_pin_src
(
    input wire logic pclk,
    input wire logic [3:0] lvl_cmd,
    output var logic [3:0] pins
);
    // ****************************************************************
    // Sources move just after an edge; the unit must resynchronise them
    // ****************************************************************
    always @(posedge pclk)
    begin
        pins <= lvl_cmd;
    end
endmodule

`default_nettype wire

// File: bench/timer_input_capture_unit_tb.sv
// Self-checking bench for the timer input capture unit
`timescale 1ns/1ps
`default_nettype none

module timer_input_capture_unit_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, wd;
    logic [15:0] t1_cnt, t3_cnt, v1, v3;
    logic [3:0] lvl_cmd, pins;
    logic [32:0] exp_q[$];
    logic [15:0] cap_m[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [7:0] c;
    logic rise;
    int error_cnt = 0;
    int num_checks = 0;
    integer seed = 32'h1d4bb8d3;

    tic_capture #(.ADDR_W(12)) tic_capture_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer1_count(t1_cnt), .timer3_count(t3_cnt),
        .capture_pin_0(pins[0]), .capture_pin_1(pins[1]), .capture_pin_2(pins[2]),
        .capture_pin_3(pins[3]));
    tic_pin_src tic_pin_src_inst (.pclk(pclk), .lvl_cmd(lvl_cmd), .pins(pins));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ****************************************************************
    // Bus master and read-data checker
    // ****************************************************************
    task automatic tally_and_finish;
        // A read whose answer never came is a mismatch too
        if (exp_q.size() != 0)
            error_cnt++;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
        input logic [32:0] exp);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        if (!wr)
            exp_q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [32:0] exp);
        apb(1'b0, idx, 32'h0000_0000, exp);
    endtask

    function automatic logic [7:0] ctl_of(input int p);
        return (p < 2) ? tic_pkg::TIMER1_CAPTURE_EDGE_CONTROL_IDX
            : tic_pkg::TIMER3_CAPTURE_EDGE_CONTROL_IDX;
    endfunction

    task automatic reset_and_read_zero;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++)
            rd(8'(ctl_of(i < 5 ? 0 : 2) + i % 5), 33'h0);
    endtask

    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
            && exp_q.size() > 0)
        begin
            num_checks++;
            if ({pslverr, prdata} !== exp_q[0])
            begin
                error_cnt++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {pslverr, prdata}, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        t1_cnt = 16'h0000;
        t3_cnt = 16'h0000;
        lvl_cmd = 4'h0;
        reset_and_read_zero();
        for (int t = 0; t < 2; t++)
        begin
            c = ctl_of(2 * t);
            wd = $random(seed) & 32'h0000_000F;
            apb(1'b1, c, wd, 33'h0);
            rd(c, {25'h0, wd[7:0]});
            apb(1'b1, 8'(c + 1), 32'h0000_00FF, 33'h0);
            rd(8'(c + 1), 33'h0);
        end
        rd(8'h70, {1'b1, 32'h0000_0000});
        // Every mode on every pin, each with one rising and one falling edge
        for (int p = 0; p < 4; p++)
            for (int m = 0; m < 4; m++)
                for (int e = 0; e < 2; e++)
                begin
                    c = ctl_of(p);
                    apb(1'b1, c, 32'(m) << (p % 2 ? 2 : 0), 33'h0);
                    v1 = 16'($random(seed));
                    v3 = 16'($random(seed));
                    rise = ~lvl_cmd[p];
                    @(posedge pclk);
                    t1_cnt <= v1;
                    t3_cnt <= v3;
                    lvl_cmd[p] <= rise;
                    if ((rise && m[1]) || (!rise && m[0]))
                        cap_m[p] = (p < 2) ? v1 : v3;
                    // Source lag plus synchroniser fits well inside this hold
                    repeat (8) @(posedge pclk);
                    rd(8'(c + 1 + 2 * (p % 2)), {25'h0, cap_m[p][7:0]});
                    rd(8'(c + 2 + 2 * (p % 2)), {25'h0, cap_m[p][15:8]});
                end
        // A second reset at the end of the run must clear every captured value again
        @(posedge pclk);
        reset_and_read_zero();
        // Let the checker take the last read before the run ends
        @(posedge pclk);
        tally_and_finish();
    end
endmodule

`default_nettype wire
